// ---- hdl/card_clock_gen.sv ----
// Card clock divider, glitch-free between divided rates, with stop level, synchronous drive and ETU edge pulses
`timescale 1ns/1ns
`include "smart_card_cfg.svh"
module card_clock_gen
	import smart_card_pkg::*;
(
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst_b,
	// Internal oscillator enable
	input wire logic int_tick,
	// Configuration and clock
	card_clock_if.gen cif
);
	div_sel_t act_q;
	logic [2:0] cnt_q;
	logic clk_q;
	logic edge_q;
	logic [2:0] half_m1;
	logic hit;
	logic hold;

	always_comb
	begin
		case (act_q[1:0])
			2'b00: half_m1 = 3'h0;
			2'b01: half_m1 = 3'h1;
			2'b10: half_m1 = 3'h3;
			default: half_m1 = 3'h7;
		endcase
	end

	assign hit = act_q[2] ? int_tick : (cnt_q == half_m1);
	// Stop only once the clock already sits at the chosen level, so no pulse is cut short
	assign hold = cif.stop && (clk_q == cif.stop_level);

	always_ff @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			act_q <= 3'h0;
			cnt_q <= 3'h0;
			clk_q <= 1'b0;
			edge_q <= 1'b0;
		end
		else if (cif.sync_mode)
		begin
			clk_q <= cif.sync_bit;
			cnt_q <= 3'h0;
			edge_q <= 1'b0;
		end
		else if (hold)
		begin
			cnt_q <= 3'h0;
			edge_q <= 1'b0;
		end
		else if (hit)
		begin
			clk_q <= ~clk_q;
			cnt_q <= 3'h0;
			edge_q <= !clk_q || (cif.doubler && act_q != 3'h0);
			// New rate taken only at a rising edge, so both halves of a divided rate are whole
			if (!clk_q)
				act_q <= cif.div_sel;
		end
		else
		begin
			cnt_q <= cnt_q + 3'h1;
			edge_q <= 1'b0;
		end
	end

	assign cif.card_clk = clk_q;
	assign cif.etu_edge = edge_q;

	property p_sync_drive;
		@(posedge ref_clk) disable iff (!rst_b)
		cif.sync_mode |=> clk_q == $past(cif.sync_bit);
	endproperty
	a_sync_drive: assert property (p_sync_drive) else $error("sync clock not copied");

	property p_stop_hold;
		@(posedge ref_clk) disable iff (!rst_b)
		(!cif.sync_mode && cif.stop && clk_q == cif.stop_level)
		##1 (!cif.sync_mode && cif.stop && $stable(cif.stop_level))
		|-> clk_q == cif.stop_level && $stable(clk_q);
	endproperty
	a_stop_hold: assert property (p_stop_hold) else $error("stopped clock moved");

	property p_switch_at_rise;
		@(posedge ref_clk) disable iff (!rst_b)
		!$stable(act_q) |-> clk_q && !$past(clk_q);
	endproperty
	a_switch_at_rise: assert property (p_switch_at_rise) else $error("rate changed mid period");
endmodule : card_clock_gen

// ---- hdl/card_clock_if.sv ----
// Configuration and clock signals between the register bank and one card clock generator
`timescale 1ns/1ns
interface card_clock_if;
	import smart_card_pkg::*;
	div_sel_t div_sel;
	logic stop;
	logic stop_level;
	logic sync_mode;
	logic sync_bit;
	logic doubler;
	logic card_clk;
	logic etu_edge;
	modport ctrl (output div_sel, stop, stop_level, sync_mode, sync_bit, doubler,
		input card_clk, etu_edge);
	modport gen (input div_sel, stop, stop_level, sync_mode, sync_bit, doubler,
		output card_clk, etu_edge);
endinterface : card_clock_if

// ---- hdl/pin_sync.sv ----
// Three-stage synchroniser for pin inputs, a change counts once stages two and three agree
`timescale 1ns/1ns
module pin_sync #(
	parameter int WIDTH = 1,
	// Reset value of every stage, so an idle-high pin shows no false edge after reset
	parameter logic [WIDTH-1:0] IDLE = '0
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst_b,
	// Pins and stable copies
	input wire logic [WIDTH-1:0] pin,
	output logic [WIDTH-1:0] stable
);
	logic [WIDTH-1:0] s1_q;
	logic [WIDTH-1:0] s2_q;
	logic [WIDTH-1:0] s3_q;

	for (genvar i = 0; i < WIDTH; i++)
	begin : g_bit
		always_ff @(posedge ref_clk or negedge rst_b)
		begin
			if (!rst_b)
			begin
				s1_q[i] <= IDLE[i];
				s2_q[i] <= IDLE[i];
				s3_q[i] <= IDLE[i];
				stable[i] <= IDLE[i];
			end
			else
			begin
				s1_q[i] <= pin[i];
				s2_q[i] <= s1_q[i];
				s3_q[i] <= s2_q[i];
				if (s2_q[i] == s3_q[i])
					stable[i] <= s3_q[i];
			end
		end
	end
endmodule : pin_sync

// ---- hdl/smart_card_cfg.svh ----
// Offsets, field positions, reset values and timing counts of the card register bank
`ifndef SMART_CARD_CFG_SVH
`define SMART_CARD_CFG_SVH

`define REF_CLK_MHZ 250
// Register offsets on the 4-bit host address
`define OFS_CARD_SELECT 4'h0
`define OFS_CLOCK_CONFIG 4'h1
`define OFS_ETU_DIVIDER 4'h2
`define OFS_UART_CTRL_TWO 4'h3
`define OFS_GUARD_TIME 4'h5
`define OFS_UART_CTRL_ONE 4'h6
`define OFS_CARD_POWER 4'h7
`define OFS_TIMEOUT_CONFIG 4'h8
`define OFS_TIMEOUT_LOW 4'h9
`define OFS_TIMEOUT_MID 4'hA
`define OFS_TIMEOUT_HIGH 4'hB
`define OFS_STATUS_FIFO 4'hC
`define OFS_UART_DATA 4'hD
`define OFS_UART_STATUS 4'hE
`define OFS_HW_STATUS 4'hF
// Implemented-bit masks
`define MASK_CLOCK_CONFIG 8'h3F
`define MASK_UART_CTRL_TWO 8'h7F
`define MASK_UART_CTRL_ONE 8'h5F
`define MASK_CARD_POWER 8'h3F
`define MASK_UART_ONE_HELD 8'hF3
// Reset values
`define RST_ZERO 8'h00
`define RST_CARD_POWER 8'h30
`define RST_MIXED_STATUS 8'h50
// Field positions
`define BIT_UART_RUN 3
`define BIT_STOP_LEVEL 5
`define BIT_STOP_ENABLE 4
`define BIT_SYNC_CLOCK 3
`define BIT_SYNC_MODE 3
`define BIT_DOUBLER 1
`define BIT_PRESCALER 0
`define BIT_TRANSMIT 3
`define BIT_LAST_CHAR 2
// Device identification, value arbitrary
`define DEVICE_ID 4'h5
// Card select codes
`define SEL_CARD_A 3'b001
`define SEL_CARD_B 3'b010
`define SEL_CARD_AUX 3'b100
// Prescaler terminal counts (31 and 32 edges)
`define PRESCALE_31 5'd30
`define PRESCALE_32 5'd31
// Internal oscillator tick, in reference cycles per half period
`define INT_OSC_DIV 8'd100
// Least hold time of the UART reset before activation
`define RIU_MIN_NS 10
`define RIU_MIN_CYC ((`RIU_MIN_NS * `REF_CLK_MHZ + 999) / 1000)

`endif

// ---- hdl/smart_card_pkg.sv ----
// Types shared by the card register bank modules
package smart_card_pkg;
	typedef logic [2:0] div_sel_t;
	typedef enum {BUS_IDLE, BUS_READ, BUS_WRITE} bus_state_t;
endpackage : smart_card_pkg

// ---- hdl/smart_card_regs.sv ----
// Host register bank of a dual smart card interface with banked per-card registers
// Functional notes
// - Divider, guard time, both UART controls and clock config exist per card.
// - Power control exists only for cards A and B.
// - Banked addresses reach only the copy of the selected card.
// - Shared addresses send reads to one register, writes to another.
// - UART data address reads receive buffer, writes transmit buffer.
// - Unimplemented bits ignore writes and read as zero.
// - Pin-reflecting status bits always show live pins, even in UART reset.
// - Card select upper nibble is a read-only device identification code.
// - UART reset-release low holds timeout config at zero, clears transmit and last-character bits, sets power bits 5:4.
// - Select codes 000 none, 001 A, 010 B, 100 aux; reset to none.
// - Stopped card clock sits low or high per stop level bit.
// - Clock stop halts selected card clock; clearing resumes divided rate.
// - Synchronous card clock pin copies the synchronous clock bit.
// - Sync mode: transmit write drives LSB to I/O; I/O reads in LSB.
// - Divide select sets card and UART clock: 1, 2, 4, 8, oscillator/2.
// - Card clock rate changes between divided rates without glitches or shortened pulses; a switch to oscillator can cut one high phase.
// - ETU is prescaler output over divider; 00h and 01h divide by one.
// - Prescaler divides by 31 when select is zero, 32 when one.
// - Doubler takes ETU from both clock edges, except undivided crystal.
`timescale 1ns/1ns
`include "smart_card_cfg.svh"
module smart_card_regs
	import smart_card_pkg::*;
(
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst_b,
	// Host parallel bus
	input wire logic cs_b,
	input wire logic wr_b,
	input wire logic rd_b,
	input wire logic [3:0] addr,
	input wire logic [7:0] data_in,
	output logic [7:0] data_out,
	output logic data_oe,
	// Card clocks
	output logic card_clk_a,
	output logic card_clk_b,
	// Card I/O lines
	input wire logic io_a_in,
	input wire logic io_b_in,
	input wire logic io_aux_in,
	output logic io_a_out,
	output logic io_b_out,
	output logic io_aux_out,
	output logic io_a_oe,
	output logic io_b_oe,
	output logic io_aux_oe,
	// Card and supply status pins
	input wire logic present_a,
	input wire logic present_b,
	input wire logic aux_int,
	input wire logic supply_low,
	input wire logic prot_limit_a,
	input wire logic prot_limit_b,
	input wire logic overheat,
	// UART timing and power sequencer controls
	output logic uart_run,
	output logic etu_tick,
	output logic [5:0] power_ctrl_a,
	output logic [5:0] power_ctrl_b
);
	localparam int NCARD = 3;
	localparam int NSYNC = 25;

	logic [NSYNC-1:0] sync_out;
	logic cs_s;
	logic wr_s;
	logic rd_s;
	logic [3:0] addr_s;
	logic [7:0] data_s;
	logic [NCARD-1:0] io_s;
	logic pres_a_s;
	logic pres_b_s;
	logic aux_s;
	logic supl_s;
	logic prtla_s;
	logic prtlb_s;
	logic ptl_s;

	bus_state_t bus_q;
	logic [3:0] cap_addr_q;
	logic [7:0] cap_data_q;
	logic acc;
	logic wr_commit;
	logic [7:0] rd_mux;

	logic riu_q;
	logic [2:0] sel_q;
	logic [1:0] idx;
	logic sel_ok;
	logic [7:0] timeout_config_q;

	logic [7:0] clock_config_q [NCARD];
	logic [7:0] etu_divider_q [NCARD];
	logic [7:0] uart_control_two_q [NCARD];
	logic [7:0] guard_time_count_q [NCARD];
	logic [7:0] uart_control_one_q [NCARD];
	logic [7:0] card_power_control_q [2];
	logic [NCARD-1:0] io_bit_q;
	logic [NCARD-1:0] io_oe_q;
	logic [NCARD-1:0] edge_w;
	logic [NCARD-1:0] clk_w;

	logic [7:0] int_cnt_q;
	logic int_tick_q;
	logic [4:0] psc_cnt_q;
	logic [7:0] div_cnt_q;
	logic etu_q;
	logic [7:0] data_out_q;
	logic data_oe_q;

	// Strobes start at their idle high level, so reset release is not taken as an access
	pin_sync #(.WIDTH(NSYNC), .IDLE({3'b111, {22{1'b0}}})) u_sync (
		.ref_clk(ref_clk),
		.rst_b(rst_b),
		.pin({cs_b, wr_b, rd_b, addr, data_in, io_aux_in, io_b_in, io_a_in,
			present_a, present_b, aux_int, supply_low, prot_limit_a, prot_limit_b, overheat}),
		.stable(sync_out)
	);
	assign {cs_s, wr_s, rd_s, addr_s, data_s, io_s, pres_a_s, pres_b_s, aux_s,
		supl_s, prtla_s, prtlb_s, ptl_s} = sync_out;

	// Host access: rd_b high selects read while chip select and strobe are low
	assign acc = !cs_s && !wr_s;
	assign wr_commit = (bus_q == BUS_WRITE) && !acc;

	always_ff @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			bus_q <= BUS_IDLE;
			cap_addr_q <= 4'h0;
			cap_data_q <= 8'h00;
			data_out_q <= 8'h00;
			data_oe_q <= 1'b0;
		end
		else
		begin
			case (bus_q)
				BUS_IDLE:
				begin
					if (acc && rd_s)
					begin
						bus_q <= BUS_READ;
						data_out_q <= rd_mux;
						data_oe_q <= 1'b1;
					end
					else if (acc)
					begin
						bus_q <= BUS_WRITE;
						cap_addr_q <= addr_s;
						cap_data_q <= data_s;
					end
				end
				BUS_READ:
				begin
					data_out_q <= rd_mux;
					if (!acc)
					begin
						bus_q <= BUS_IDLE;
						data_oe_q <= 1'b0;
					end
				end
				BUS_WRITE:
				begin
					// Data is taken as it stands at the close of the strobe
					if (acc)
					begin
						cap_addr_q <= addr_s;
						cap_data_q <= data_s;
					end
					else
						bus_q <= BUS_IDLE;
				end
				default: bus_q <= BUS_IDLE;
			endcase
		end
	end

	always_comb
	begin
		idx = 2'd0;
		sel_ok = 1'b0;
		case (sel_q)
			`SEL_CARD_A:
			begin
				idx = 2'd0;
				sel_ok = 1'b1;
			end
			`SEL_CARD_B:
			begin
				idx = 2'd1;
				sel_ok = 1'b1;
			end
			`SEL_CARD_AUX:
			begin
				idx = 2'd2;
				sel_ok = 1'b1;
			end
			default: sel_ok = 1'b0;
		endcase
	end

	// Card select: identification nibble is constant, reset-release and select are stored
	always_ff @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			riu_q <= 1'b0;
			sel_q <= 3'b000;
		end
		else if (wr_commit && cap_addr_q == `OFS_CARD_SELECT)
		begin
			riu_q <= cap_data_q[`BIT_UART_RUN];
			sel_q <= cap_data_q[2:0];
		end
	end

	always_ff @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
			timeout_config_q <= `RST_ZERO;
		else if (!riu_q)
			timeout_config_q <= `RST_ZERO;
		else if (wr_commit && cap_addr_q == `OFS_TIMEOUT_CONFIG)
			timeout_config_q <= cap_data_q;
	end

	// One register copy and one clock generator per card interface
	for (genvar i = 0; i < NCARD; i++)
	begin : g_card
		card_clock_if cif ();
		logic hit;
		assign hit = wr_commit && sel_ok && idx == 2'(i);

		always_ff @(posedge ref_clk or negedge rst_b)
		begin
			if (!rst_b)
			begin
				clock_config_q[i] <= `RST_ZERO;
				etu_divider_q[i] <= `RST_ZERO;
				uart_control_two_q[i] <= `RST_ZERO;
				guard_time_count_q[i] <= `RST_ZERO;
				uart_control_one_q[i] <= `RST_ZERO;
			end
			else
			begin
				if (hit && cap_addr_q == `OFS_CLOCK_CONFIG)
					clock_config_q[i] <= cap_data_q & `MASK_CLOCK_CONFIG;
				if (hit && cap_addr_q == `OFS_ETU_DIVIDER)
					etu_divider_q[i] <= cap_data_q;
				if (hit && cap_addr_q == `OFS_UART_CTRL_TWO)
					uart_control_two_q[i] <= cap_data_q & `MASK_UART_CTRL_TWO;
				if (hit && cap_addr_q == `OFS_GUARD_TIME)
					guard_time_count_q[i] <= cap_data_q;
				// Transmit and last-character bits cannot be set while the UART is held
				if (hit && cap_addr_q == `OFS_UART_CTRL_ONE)
					uart_control_one_q[i] <= cap_data_q & `MASK_UART_CTRL_ONE
						& (riu_q ? 8'hFF : `MASK_UART_ONE_HELD);
				else if (!riu_q)
					uart_control_one_q[i][`BIT_TRANSMIT:`BIT_LAST_CHAR] <= 2'b00;
			end
		end

		// Synchronous I/O: the latest transmit LSB is driven while in transmit
		always_ff @(posedge ref_clk or negedge rst_b)
		begin
			if (!rst_b)
			begin
				io_bit_q[i] <= 1'b0;
				io_oe_q[i] <= 1'b0;
			end
			else
			begin
				if (hit && cap_addr_q == `OFS_UART_DATA && uart_control_two_q[i][`BIT_SYNC_MODE])
					io_bit_q[i] <= cap_data_q[0];
				io_oe_q[i] <= uart_control_two_q[i][`BIT_SYNC_MODE]
					&& uart_control_one_q[i][`BIT_TRANSMIT];
			end
		end

		assign cif.div_sel = clock_config_q[i][2:0];
		assign cif.stop = clock_config_q[i][`BIT_STOP_ENABLE];
		assign cif.stop_level = clock_config_q[i][`BIT_STOP_LEVEL];
		assign cif.sync_mode = uart_control_two_q[i][`BIT_SYNC_MODE];
		assign cif.sync_bit = clock_config_q[i][`BIT_SYNC_CLOCK];
		assign cif.doubler = uart_control_two_q[i][`BIT_DOUBLER];
		assign edge_w[i] = cif.etu_edge;
		assign clk_w[i] = cif.card_clk;

		card_clock_gen u_gen (
			.ref_clk(ref_clk),
			.rst_b(rst_b),
			.int_tick(int_tick_q),
			.cif(cif)
		);
	end

	for (genvar j = 0; j < 2; j++)
	begin : g_power
		always_ff @(posedge ref_clk or negedge rst_b)
		begin
			if (!rst_b)
				card_power_control_q[j] <= `RST_CARD_POWER;
			else if (wr_commit && sel_ok && idx == 2'(j) && cap_addr_q == `OFS_CARD_POWER)
				card_power_control_q[j] <= (cap_data_q & `MASK_CARD_POWER)
					| (riu_q ? 8'h00 : `RST_CARD_POWER);
			else if (!riu_q)
				card_power_control_q[j][5:4] <= 2'b11;
		end
	end

	// Internal oscillator stand-in: one enable pulse per half period
	always_ff @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			int_cnt_q <= 8'h00;
			int_tick_q <= 1'b0;
		end
		else
		begin
			int_tick_q <= int_cnt_q == `INT_OSC_DIV - 8'h01;
			int_cnt_q <= (int_cnt_q == `INT_OSC_DIV - 8'h01) ? 8'h00 : int_cnt_q + 8'h01;
		end
	end

	// ETU: selected card clock edges through the prescaler, then the divider
	always_ff @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			psc_cnt_q <= 5'h00;
			div_cnt_q <= 8'h00;
			etu_q <= 1'b0;
		end
		else if (!riu_q || !sel_ok)
		begin
			psc_cnt_q <= 5'h00;
			div_cnt_q <= 8'h00;
			etu_q <= 1'b0;
		end
		else
		begin
			etu_q <= 1'b0;
			if (edge_w[idx])
			begin
				if (psc_cnt_q == (uart_control_two_q[idx][`BIT_PRESCALER] ?
					`PRESCALE_32 : `PRESCALE_31))
				begin
					psc_cnt_q <= 5'h00;
					// Values below two divide by one; a full 256 count is not offered
					if (etu_divider_q[idx] < 8'h02 || div_cnt_q == etu_divider_q[idx] - 8'h01)
					begin
						div_cnt_q <= 8'h00;
						etu_q <= 1'b1;
					end
					else
						div_cnt_q <= div_cnt_q + 8'h01;
				end
				else
					psc_cnt_q <= psc_cnt_q + 5'h01;
			end
		end
	end

	always_comb
	begin
		rd_mux = 8'h00;
		case (addr_s)
			`OFS_CARD_SELECT: rd_mux = {`DEVICE_ID, riu_q, sel_q};
			`OFS_CLOCK_CONFIG: rd_mux = sel_ok ? clock_config_q[idx] : 8'h00;
			`OFS_ETU_DIVIDER: rd_mux = sel_ok ? etu_divider_q[idx] : 8'h00;
			`OFS_UART_CTRL_TWO: rd_mux = sel_ok ? uart_control_two_q[idx] : 8'h00;
			`OFS_GUARD_TIME: rd_mux = sel_ok ? guard_time_count_q[idx] : 8'h00;
			`OFS_UART_CTRL_ONE: rd_mux = sel_ok ? uart_control_one_q[idx] : 8'h00;
			`OFS_CARD_POWER: rd_mux = (sel_ok && idx != 2'd2) ? card_power_control_q[idx[0]] : 8'h00;
			`OFS_TIMEOUT_CONFIG: rd_mux = timeout_config_q;
			`OFS_STATUS_FIFO: rd_mux = `RST_MIXED_STATUS | {4'h0, pres_b_s, pres_a_s, aux_s, 1'b0};
			`OFS_UART_DATA: rd_mux = (sel_ok && uart_control_two_q[idx][`BIT_SYNC_MODE]) ?
				{7'h00, io_s[idx]} : 8'h00;
			`OFS_HW_STATUS: rd_mux = {1'b0, prtlb_s, prtla_s, supl_s, pres_b_s, pres_a_s, aux_s, ptl_s};
			default: rd_mux = 8'h00;
		endcase
	end

	assign data_out = data_out_q;
	assign data_oe = data_oe_q;
	assign card_clk_a = clk_w[0];
	assign card_clk_b = clk_w[1];
	assign io_a_out = io_bit_q[0];
	assign io_b_out = io_bit_q[1];
	assign io_aux_out = io_bit_q[2];
	assign io_a_oe = io_oe_q[0];
	assign io_b_oe = io_oe_q[1];
	assign io_aux_oe = io_oe_q[2];
	assign uart_run = riu_q;
	assign etu_tick = etu_q;
	assign power_ctrl_a = card_power_control_q[0][5:0];
	assign power_ctrl_b = card_power_control_q[1][5:0];

	property p_id_read;
		@(posedge ref_clk) disable iff (!rst_b)
		(acc && rd_s && addr_s == `OFS_CARD_SELECT) |=> data_oe_q && data_out_q[7:4] == `DEVICE_ID;
	endproperty
	a_id_read: assert property (p_id_read) else $error("identification nibble wrong");

	property p_reserved_zero;
		@(posedge ref_clk) disable iff (!rst_b)
		(acc && rd_s && addr_s == `OFS_CLOCK_CONFIG) |=> data_out_q[7:6] == 2'b00;
	endproperty
	a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits not zero");

	property p_live_pins;
		@(posedge ref_clk) disable iff (!rst_b)
		(acc && rd_s && addr_s == `OFS_HW_STATUS)
		|=> data_out_q[3:1] == $past({pres_b_s, pres_a_s, aux_s});
	endproperty
	a_live_pins: assert property (p_live_pins) else $error("pin status not live");

	property p_no_card_write;
		@(posedge ref_clk) disable iff (!rst_b)
		(wr_commit && !sel_ok) |=> $stable(etu_divider_q[0]) && $stable(guard_time_count_q[1]);
	endproperty
	a_no_card_write: assert property (p_no_card_write) else $error("write with no card");

	property p_uart_held;
		@(posedge ref_clk) disable iff (!rst_b)
		!riu_q [*2] |-> timeout_config_q == 8'h00 && !etu_q;
	endproperty
	a_uart_held: assert property (p_uart_held) else $error("UART state not held");

	property p_sync_tx;
		@(posedge ref_clk) disable iff (!rst_b)
		(wr_commit && sel_ok && idx == 2'd0 && cap_addr_q == `OFS_UART_DATA
			&& uart_control_two_q[0][`BIT_SYNC_MODE]) |=> io_a_out == $past(cap_data_q[0]);
	endproperty
	a_sync_tx: assert property (p_sync_tx) else $error("sync transmit bit lost");

	property p_bank_route;
		@(posedge ref_clk) disable iff (!rst_b)
		(wr_commit && sel_q == `SEL_CARD_A && cap_addr_q == `OFS_GUARD_TIME)
		|=> guard_time_count_q[0] == $past(cap_data_q) && $stable(guard_time_count_q[2]);
	endproperty
	a_bank_route: assert property (p_bank_route) else $error("banked write misrouted");

	property p_select_decode;
		@(posedge ref_clk) disable iff (!rst_b)
		sel_ok == (sel_q == 3'b001 || sel_q == 3'b010 || sel_q == 3'b100);
	endproperty
	a_select_decode: assert property (p_select_decode) else $error("select decode wrong");

	property p_aux_no_power;
		@(posedge ref_clk) disable iff (!rst_b)
		(acc && rd_s && addr_s == `OFS_CARD_POWER && sel_q == `SEL_CARD_AUX) |=> data_out_q == 8'h00;
	endproperty
	a_aux_no_power: assert property (p_aux_no_power) else $error("aux power register seen");
endmodule : smart_card_regs

// ---- sim/host_bus.sv ----
// Host microcontroller model driving the parallel register bus
`timescale 1ns/1ns
module host_bus (
	// Clock and read data
	input wire logic ref_clk,
	input wire logic [7:0] data_out,
	// Bus strobes and lines
	output logic cs_b,
	output logic wr_b,
	output logic rd_b,
	output logic [3:0] addr,
	output logic [7:0] data_in
);
	initial
	begin
		cs_b = 1'b1;
		wr_b = 1'b1;
		rd_b = 1'b1;
		addr = 4'h0;
		data_in = 8'h00;
	end
	// Strobes outlast the three-flop synchroniser; the gap lets data_oe fall first
	task automatic acc(input logic rd, input logic [3:0] a, input logic [7:0] d,
		output logic [7:0] q);
		@(posedge ref_clk);
		cs_b <= 1'b0;
		wr_b <= 1'b0;
		rd_b <= rd;
		addr <= a;
		data_in <= rd ? ~data_in : d;
		repeat (8) @(posedge ref_clk);
		q = data_out;
		cs_b <= 1'b1;
		wr_b <= 1'b1;
		data_in <= ~data_in;
		repeat (8) @(posedge ref_clk);
	endtask : acc
endmodule : host_bus

// ---- sim/test_smart_card_regs.sv ----
// Self-checking bench for the card register bank
`timescale 1ns/1ns
`include "smart_card_cfg.svh"
module test_smart_card_regs;
	logic ref_clk = 1'b0;
	logic rst_b = 1'b0;
	logic io_a_in = 1'b0;
	logic [6:0] pins = 7'h00;
	logic msel = 1'b0;
	logic cs_b, wr_b, rd_b, data_oe, card_clk_a, card_clk_b, uart_run, etu_tick;
	logic io_a_out, io_b_out, io_aux_out, io_a_oe, io_b_oe, io_aux_oe;
	logic [3:0] addr;
	logic [7:0] data_in, data_out;
	logic [5:0] power_ctrl_a, power_ctrl_b;
	int n_fail = 0;
	int checks = 0;
	int cyc = 0;
	wire mon = msel ? etu_tick : card_clk_a;

	always #2 ref_clk = ~ref_clk;

	host_bus i_host (.ref_clk, .data_out, .cs_b, .wr_b, .rd_b, .addr, .data_in);
	smart_card_regs i_dut (.ref_clk, .rst_b, .cs_b, .wr_b, .rd_b, .addr, .data_in,
		.data_out, .data_oe, .card_clk_a, .card_clk_b, .io_a_in, .io_b_in(1'b0),
		.io_aux_in(1'b0), .io_a_out, .io_b_out, .io_aux_out, .io_a_oe, .io_b_oe, .io_aux_oe,
		.overheat(pins[0]), .aux_int(pins[1]), .present_a(pins[2]), .present_b(pins[3]),
		.supply_low(pins[4]), .prot_limit_a(pins[5]), .prot_limit_b(pins[6]),
		.uart_run, .etu_tick, .power_ctrl_a, .power_ctrl_b);

	task automatic end_sim;
		if (n_fail == 0 && checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : end_sim

	always @(posedge ref_clk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			n_fail++;
			end_sim();
		end
	end

	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		checks++;
		if (seen !== exp)
		begin
			n_fail++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		logic [7:0] q;
		i_host.acc(1'b0, a, d, q);
	endtask : wr

	task automatic rd(input logic [3:0] a, input logic [7:0] e);
		logic [7:0] q;
		i_host.acc(1'b1, a, 8'h00, q);
		chk(q, e);
	endtask : rd

	// First two rising edges only align: a switch lands on one, and a switch to the
	// free-running oscillator tick leaves one odd period after it
	task automatic period(input int e);
		logic p;
		int n;
		repeat (3)
		begin
			p = 1'b1;
			for (n = 1; n < 3000; n++)
			begin
				@(negedge ref_clk);
				if (mon === 1'b1 && p === 1'b0)
					break;
				p = mon;
			end
		end
		chk(16'(n), 16'(e));
	endtask : period

	task automatic t_reset;
		rd(4'h0, {`DEVICE_ID, 4'h0});
		chk(power_ctrl_a, 6'h30);
		rd(4'h7, 8'h00);
		wr(4'h0, 8'hF1);
		rd(4'h0, {`DEVICE_ID, 4'h1});
	endtask : t_reset

	task automatic t_bank;
		for (int i = 0; i < 3; i++)
		begin
			wr(4'h0, 8'(1 << i));
			wr(4'h2, 8'hA0 + 8'(i));
		end
		for (int i = 0; i < 3; i++)
		begin
			wr(4'h0, 8'(1 << i));
			rd(4'h2, 8'hA0 + 8'(i));
		end
		wr(4'h0, 8'h00);
		wr(4'h2, 8'hFF);
		rd(4'h2, 8'h00);
		wr(4'h7, 8'h0F);
		rd(4'h7, 8'h00);
		wr(4'h0, 8'h01);
		rd(4'h2, 8'hA0);
		wr(4'h5, 8'h5A);
		wr(4'h0, 8'h04);
		wr(4'h7, 8'h0F);
		rd(4'h7, 8'h00);
		rd(4'h5, 8'h00);
		wr(4'h0, 8'h01);
		rd(4'h5, 8'h5A);
		wr(4'h7, 8'h0F);
		rd(4'h7, 8'h3F);
		chk({power_ctrl_a, power_ctrl_b}, {6'h3F, 6'h30});
	endtask : t_bank

	task automatic t_bits;
		wr(4'h1, 8'hC0);
		rd(4'h1, 8'h00);
		wr(4'h6, 8'hFF);
		rd(4'h6, 8'h53);
		wr(4'h0, 8'h09);
		chk(uart_run, 1'b1);
		wr(4'h6, 8'hFF);
		rd(4'h6, 8'h5F);
		wr(4'h0, 8'h01);
		rd(4'h6, 8'h53);
	endtask : t_bits

	task automatic t_status(input logic [6:0] p);
		@(posedge ref_clk);
		pins <= p;
		wr(4'hC, 8'hFF);
		rd(4'hF, {1'b0, p});
		rd(4'hC, 8'h50 | {4'h0, p[3:1], 1'b0});
		wr(4'hD, 8'hAA);
		rd(4'hD, 8'h00);
	endtask : t_status

	task automatic t_clock;
		for (int k = 0; k < 5; k++)
		begin
			wr(4'h1, 8'(k));
			period(k < 4 ? 2 << k : 2 * `INT_OSC_DIV);
		end
		// Leave the slow oscillator rate first, so the stop level is reached at once
		wr(4'h1, 8'h01);
		period(4);
		for (int s = 0; s < 2; s++)
		begin
			wr(4'h1, s ? 8'h11 : 8'h31);
			repeat (4)
			begin
				repeat (5) @(negedge ref_clk);
				chk(card_clk_a, s ? 1'b0 : 1'b1);
			end
		end
		wr(4'h1, 8'h01);
		period(4);
		wr(4'h3, 8'h08);
		wr(4'h1, 8'h08);
		chk(card_clk_a, 1'b1);
		wr(4'h1, 8'h00);
		chk(card_clk_a, 1'b0);
		wr(4'h0, 8'h09);
		wr(4'h6, 8'h08);
		wr(4'hD, 8'h03);
		chk({io_a_oe, io_a_out}, 2'b11);
		chk({io_b_oe, io_aux_oe}, 2'b00);
		wr(4'hD, 8'h02);
		chk({io_a_oe, io_a_out}, 2'b10);
		@(posedge ref_clk);
		io_a_in <= 1'b1;
		rd(4'hD, 8'h01);
		wr(4'h3, 8'h00);
	endtask : t_clock

	task automatic t_etu;
		logic [7:0] dv[4] = '{8'h00, 8'h00, 8'h00, 8'h01};
		logic [7:0] uc[4] = '{8'h00, 8'h01, 8'h03, 8'h03};
		logic [7:0] pd[4] = '{8'h02, 8'h01, 8'h00, 8'h03};
		int sp;
		msel = 1'b1;
		for (int i = 0; i < 4; i++)
		begin
			wr(4'h1, dv[i]);
			wr(4'h3, uc[i]);
			wr(4'h2, pd[i]);
			sp = (uc[i][1] && dv[i] != 0) ? 1 << dv[i] : 2 << dv[i];
			period(sp * (uc[i][0] ? 32 : 31) * (pd[i] < 2 ? 1 : pd[i]));
		end
	endtask : t_etu

	initial
	begin
		repeat (10) @(posedge ref_clk);
		rst_b <= 1'b1;
		t_reset();
		t_bank();
		t_bits();
		t_status(7'h55);
		t_status(7'h2A);
		t_clock();
		t_etu();
		end_sim();
	end
endmodule : test_smart_card_regs
